// ===== bench/rsc_mem_model.sv
// External memory that answers a selected access with an acknowledge.
// Assumes the acknowledge line has a pull-up, so it reads high when released.
`timescale 1ns/100ps
module rsc_mem_model
(
  input wire core_clk,
  input wire region_select_n,
  input wire [3:0] ack_delay,
  output reg transfer_acknowledge_n
);
  reg [3:0] wait_q;
  initial transfer_acknowledge_n = 1'b1;
  initial wait_q = 4'h0;
  // Pulls the acknowledge low after the set delay and releases it with the select.
  always @(posedge core_clk)
  begin
    if (region_select_n)
    begin
      wait_q <= 4'h0;
      transfer_acknowledge_n <= 1'b1;
    end
    else if (wait_q == ack_delay)
      transfer_acknowledge_n <= 1'b0;
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule

// ===== bench/rsc_top_props.sv
// Checker for the region select control block.
// Assumes it is bound to rsc_top and sees only its ports.
`timescale 1ns/100ps
`include "rsc_map.vh"
module rsc_top_props
#(
  parameter ADDR_W = 24,
  parameter IS_FOURTH_REGION = 0
)
(
  // Clock, reset and APB.
  input wire core_clk, input wire arst_n,
  input wire psel, input wire penable, input wire pwrite,
  input wire [11:0] paddr, input wire [31:0] pwdata,
  // Processor side.
  input wire cpu_req, input wire cpu_write, input wire cpu_supervisor,
  input wire [ADDR_W-1:0] cpu_addr, input wire [ADDR_W-1:0] region_base,
  input wire cpu_done, input wire cpu_bus_error, input wire bus_wide,
  // Memory pins.
  input wire transfer_acknowledge_n, input wire region_select_n,
  input wire lower_write_strobe_n, input wire upper_write_strobe_n
);
  reg [15:0] ctrl_q;
  reg one_q;
  reg ben_q;
  reg dram_q;
  reg [5:0] cnt_q;
  wire [ADDR_W-1:0] off = cpu_addr - region_base;
  // On the fourth region with DRAM on, bit 8 doubles the size instead of delaying the strobes.
  wire ext = (IS_FOURTH_REGION != 0) && dram_q && ctrl_q[8];
  wire lead = ctrl_q[8] && !ext;
  wire hit = ctrl_q[0] && ((off >> (15 + ctrl_q[3:1] + ext)) == 0);
  wire prot = (off >> (15 + ctrl_q[12:11])) != 0;
  wire ben_sop = !cpu_supervisor && prot && ctrl_q[14] && ben_q;
  wire fault = hit && ((cpu_write && ctrl_q[15] && ben_q) || ben_sop || (cpu_write && prot && ctrl_q[13]));
  wire apb_wr = psel && penable && pwrite;
  wire wr_ctrl = apb_wr && (paddr == `RSC_ADDR_CTRL);
  wire [2:0] ws = ctrl_q[6:4];
  // Shadow copies of the registers, and a count of edges with a request held.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= 16'h0000;
      one_q <= 1'b0;
      ben_q <= 1'b0;
      dram_q <= 1'b0;
      cnt_q <= 6'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= pwdata[15:0] & `RSC_CTRL_WMASK;
      if (apb_wr && (paddr == `RSC_ADDR_ONE))
        one_q <= pwdata[0];
      if (apb_wr && (paddr == `RSC_ADDR_SYS))
      begin
        ben_q <= pwdata[0];
        dram_q <= pwdata[1];
      end
      cnt_q <= cpu_req ? cnt_q + 6'h01 : 6'h00;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  width_follow_a: assert property (wr_ctrl ##1 !wr_ctrl |=> bus_wide == ctrl_q[7])
    else $error("bus width level differs from control bit");
  upper_wide_a: assert property (!upper_write_strobe_n |-> bus_wide && !region_select_n)
    else $error("upper strobe on a narrow bus");
  flash_lead_a: assert property ($fell(region_select_n) && cpu_write |-> lower_write_strobe_n == lead)
    else $error("write strobe timing against select is wrong");
  done_pulse_a: assert property (cpu_done |=> !cpu_done)
    else $error("done pulse longer than one cycle");
  wait_count_a: assert property (cpu_done && ws != 3'h7 |->
    cnt_q == 6'(2 * ws + one_q + 2 + (lead & cpu_write)))
    else $error("wait state count wrong");
  ext_ack_a: assert property (cpu_done && ws == 3'h7 |-> !$past(transfer_acknowledge_n, 2))
    else $error("access ended without acknowledge");
  fault_raise_a: assert property ($rose(cpu_req) && fault |=> cpu_bus_error && region_select_n)
    else $error("protection fault not raised");
  clean_access_a: assert property ($rose(cpu_req) && hit && !fault |=> !cpu_bus_error)
    else $error("bus error on an allowed access");
  miss_idle_a: assert property ($rose(cpu_req) && !hit |=> region_select_n && !cpu_done)
    else $error("select on a miss or disabled region");
  error_quiet_a: assert property (cpu_bus_error |-> region_select_n && !cpu_done)
    else $error("faulted access was run");
  cover property (cpu_bus_error);
  cover property (cpu_done && ws == 3'h7);
  cover property ($fell(region_select_n) && lead && cpu_write);
endmodule
bind rsc_top rsc_top_props #(.ADDR_W(ADDR_W), .IS_FOURTH_REGION(IS_FOURTH_REGION)) u_props (.core_clk(core_clk),
  .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cpu_req(cpu_req), .cpu_write(cpu_write),
  .cpu_supervisor(cpu_supervisor), .cpu_addr(cpu_addr), .region_base(region_base), .cpu_done(cpu_done),
  .cpu_bus_error(cpu_bus_error), .bus_wide(bus_wide), .transfer_acknowledge_n(transfer_acknowledge_n),
  .region_select_n(region_select_n), .lower_write_strobe_n(lower_write_strobe_n),
  .upper_write_strobe_n(upper_write_strobe_n));

// ===== bench/rsc_top_test.sv
// Testbench for the region select control block.
// Assumes the checker is bound in and the memory model answers.
`timescale 1ns/100ps
module rsc_top_test;
  reg core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg cpu_req = 1'b0, cpu_write = 1'b0, cpu_supervisor = 1'b0;
  reg [23:0] cpu_addr = 24'h0;
  reg [3:0] ack_delay = 4'h6;
  wire [31:0] prdata;
  wire pready, pslverr, cpu_done, cpu_bus_error, bus_wide, ack_n, sel_n, lws_n, uws_n;
  integer errors = 0, total_checks = 0, i;
  rsc_top #(.ADDR_W(24), .WAIT_W(4), .IS_FOURTH_REGION(1)) DUT (.core_clk(core_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req), .cpu_write(cpu_write),
    .cpu_supervisor(cpu_supervisor), .cpu_addr(cpu_addr), .region_base(24'h100000), .cpu_done(cpu_done),
    .cpu_bus_error(cpu_bus_error), .bus_wide(bus_wide), .transfer_acknowledge_n(ack_n),
    .region_select_n(sel_n), .lower_write_strobe_n(lws_n), .upper_write_strobe_n(uws_n));
  rsc_mem_model mem (.core_clk(core_clk), .region_select_n(sel_n), .ack_delay(ack_delay),
    .transfer_acknowledge_n(ack_n));
  // Free-running core clock.
  initial forever #25 core_clk = ~core_clk;
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One APB transfer; read data is taken at the edge where pready is seen.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    if (!wr)
      check(prdata, exp);
    check(pslverr, 0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One processor access; exp_n counts edges to the answer, 0 means no answer, below 0 a count that must be exceeded.
  // The answer is sampled at the edge, and the request is dropped at that same edge.
  task acc(input logic wr, input logic sup, input logic [23:0] off, input logic err, input integer exp_n);
    integer n;
    n = 0;
    @(posedge core_clk);
    cpu_req <= 1'b1;
    cpu_write <= wr;
    cpu_supervisor <= sup;
    cpu_addr <= 24'h100000 + off;
    while (n < 40 && cpu_done !== 1'b1 && cpu_bus_error !== 1'b1)
    begin
      @(posedge core_clk);
      n++;
    end
    cpu_req <= 1'b0;
    if (exp_n == 0)
      check({cpu_done, cpu_bus_error}, 2'b00);
    else if (exp_n < 0)
      check({cpu_done, n > -exp_n}, 2'b11);
    else
      check({cpu_bus_error, 8'(n)}, {err, 8'(exp_n)});
    @(posedge core_clk);
  endtask
  task prot(input logic [15:0] c, input logic ben, input logic wr, input logic sup, input logic [23:0] off,
    input logic err);
    apb(1, 12'h000, c, 0);
    apb(1, 12'h008, ben, 0);
    acc(wr, sup, off, err, err ? 2 : 3);
  endtask
  // Main sequence.
  initial
  begin
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (i = 0; i < 5; i++)
      apb(0, 12'(4 * i), 0, 0);
    apb(1, 12'h000, 32'hF9FF, 0);
    apb(0, 12'h000, 0, 32'hF9FE);
    for (i = 0; i < 7; i++)
    begin
      apb(1, 12'h004, i & 1, 0);
      apb(1, 12'h000, 16'h0009 | (i & 2) << 6 | i << 4, 0);
      acc(0, 1, 24'h0, 0, 2 * i + (i & 1) + 3);
      check(bus_wide, (i >> 1) & 1);
    end
    apb(1, 12'h004, 0, 0);
    apb(1, 12'h000, 16'h0109, 0);
    acc(1, 1, 24'h0, 0, 4);
    apb(1, 12'h000, 16'h0089, 0);
    acc(1, 1, 24'h0, 0, 3);
    prot(16'h8009, 1, 1, 1, 24'h0, 1);
    apb(0, 12'h00C, 0, 32'h11);
    apb(1, 12'h00C, 0, 0);
    apb(0, 12'h00C, 0, 32'h01);
    prot(16'h8009, 0, 1, 1, 24'h0, 0);
    prot(16'h8009, 1, 0, 1, 24'h0, 0);
    prot(16'h4009, 1, 0, 0, 24'h8000, 1);
    prot(16'h4009, 1, 0, 1, 24'h8000, 0);
    prot(16'h4009, 1, 0, 0, 24'h0, 0);
    prot(16'h2009, 0, 1, 1, 24'h8000, 1);
    prot(16'h2009, 0, 0, 1, 24'h8000, 0);
    for (i = 0; i < 4; i++)
    begin
      prot(16'h2009 | i << 11, 0, 1, 1, (24'h8000 << i) - 2, 0);
      prot(16'h2009 | i << 11, 0, 1, 1, 24'h8000 << i, 1);
    end
    acc(0, 1, 24'h80000, 0, 0);
    apb(1, 12'h000, 16'h0079, 0);
    acc(0, 1, 24'h0, 0, -6);
    apb(1, 12'h008, 2, 0);
    apb(1, 12'h000, 16'h0109, 0);
    acc(1, 1, 24'h80000, 0, 3);
    apb(1, 12'h000, 16'h0008, 0);
    acc(0, 1, 24'h0, 0, 0);
    end_of_test;
  end
  // Cuts a hang short.
  initial
  begin
    #1000000;
    errors++;
    end_of_test;
  end
endmodule

// ===== logic/rsc_map.vh
// Constants for the region select control block: register offsets, field positions and reset values.
// Assumes a 20 MHz core clock and an APB register bus with 32-bit data.
//
// Behaviour
// - When the region write-protect bit 15 is set, a write anywhere in the region gives a bus error if the bus-error timer is enabled.
// - When bit 14 is set, a user access to the protected block gives a bus error if the bus-error timer is enabled.
// - When bit 13 is set, any write to the protected block gives a bus error.
// - Bits 12 to 11 size the unprotected block as 32K, 64K, 128K or 256K.
// - With bit 8 clear the select and write strobes assert on the same edge; with it set the select leads them by one clock.
// - Bit 7 selects an 8-bit bus when 0 and a 16-bit bus when 1.
// - Wait codes 000 to 110 insert twice the code plus the extra wait bit before the internal acknowledge.
// - Wait code 111 ends the access only on the external transfer acknowledge, which the outside device drives.
// - The extra wait bit comes from this region group's own bit in the first select control register.
// - For the fourth region with its DRAM bit enabled, bit 8 extends the memory size instead of delaying the strobes.
// - Bits 3 to 1 set the region size, each step doubling it, within the range of the region group.
// - The region select asserts only while enable bit 0 is 1.
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
`define RSC_ADDR_CTRL 12'h000
`define RSC_ADDR_ONE 12'h004
`define RSC_ADDR_SYS 12'h008
`define RSC_ADDR_STAT 12'h00C
`define RSC_BIT_RO 15
`define RSC_BIT_SOP 14
`define RSC_BIT_ROP 13
`define RSC_UP_HI 12
`define RSC_UP_LO 11
`define RSC_BIT_FLASH 8
`define RSC_BIT_BSW 7
`define RSC_WS_HI 6
`define RSC_WS_LO 4
`define RSC_SIZ_HI 3
`define RSC_SIZ_LO 1
`define RSC_BIT_EN 0
`define RSC_CTRL_WMASK 16'hF9FF
`define RSC_CTRL_RST 16'h0000
`define RSC_ONE_RST 8'h00
`define RSC_SYS_RST 8'h00
`define RSC_WS_EXT 3'h7
`define RSC_UP_BASE_LOG2 15
`define RSC_SIZ_BASE_LOG2 15
`endif

// ===== logic/rsc_sync3.v
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk; the first stage feeds only the second.
`timescale 1ns/100ps
module rsc_sync3
(
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Asynchronous input and filtered level.
  input wire din,
  output reg dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // Shift the input and update the output once stages two and three agree.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        dout <= s3_reg;
    end
  end
endmodule

// ===== logic/rsc_top.v
// Region select control: APB registers, address decode, protection checks and access timing.
// Assumes a processor request port on core_clk and external memory that may drive an acknowledge pin.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "rsc_map.vh"
module rsc_top
#(
  parameter ADDR_W = 24,
  parameter WAIT_W = 4,
  parameter IS_FOURTH_REGION = 0
)
(
  // Clock and reset.
  input wire core_clk,
  input wire arst_n,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Processor access request.
  input wire cpu_req,
  input wire cpu_write,
  input wire cpu_supervisor,
  input wire [ADDR_W-1:0] cpu_addr,
  input wire [ADDR_W-1:0] region_base,
  output reg cpu_done,
  output reg cpu_bus_error,
  output reg bus_wide,
  // External memory pins.
  input wire transfer_acknowledge_n,
  output reg region_select_n,
  output reg lower_write_strobe_n,
  output reg upper_write_strobe_n
);
  localparam ST_IDLE = 3'd0;
  localparam ST_LEAD = 3'd1;
  localparam ST_WAIT = 3'd2;
  localparam ST_EXT = 3'd3;
  localparam ST_END = 3'd4;

  reg rst_a_reg;
  reg rst_b_reg;
  wire rst_n;
  reg [15:0] region_select_control_c_reg;
  reg [7:0] select_control_one_reg;
  reg [7:0] system_control_register_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [WAIT_W-1:0] wait_reg;
  reg [WAIT_W-1:0] wait_next;
  reg err_sticky_reg;
  wire ack_sync;
  wire region_write_protect;
  wire protected_block_privileged_only;
  wire protected_block_write_protect;
  wire [1:0] unprotected_block_size;
  wire flash_delay;
  wire bus_width_select;
  wire [2:0] wait_count_code;
  wire [2:0] region_size;
  wire region_enable;
  wire extra_wait_bit;
  wire bus_error_timer_enable;
  wire dram_enable;
  wire [ADDR_W-1:0] offset;
  wire [5:0] size_log2;
  wire [5:0] up_log2;
  wire hit;
  wire in_protected;
  wire fault;
  wire [WAIT_W-1:0] wait_load;
  wire apb_wr;

  // Release the asynchronous reset through two flip-flops.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_a_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end
    else
    begin
      rst_a_reg <= 1'b1;
      rst_b_reg <= rst_a_reg;
    end
  end
  assign rst_n = rst_b_reg;

  // Bring the acknowledge pin into the clock domain, inverted first.
  // The filter resets to zero, which then matches the idle pin, so no false acknowledge follows reset.
  rsc_sync3 u_ack_sync
  (
    .clk(core_clk),
    .rst_n(rst_n),
    .din(~transfer_acknowledge_n),
    .dout(ack_sync)
  );

  // Field decode of the control registers.
  assign region_write_protect = region_select_control_c_reg[`RSC_BIT_RO];
  assign protected_block_privileged_only = region_select_control_c_reg[`RSC_BIT_SOP];
  assign protected_block_write_protect = region_select_control_c_reg[`RSC_BIT_ROP];
  assign unprotected_block_size = region_select_control_c_reg[`RSC_UP_HI:`RSC_UP_LO];
  assign bus_width_select = region_select_control_c_reg[`RSC_BIT_BSW];
  assign wait_count_code = region_select_control_c_reg[`RSC_WS_HI:`RSC_WS_LO];
  assign region_size = region_select_control_c_reg[`RSC_SIZ_HI:`RSC_SIZ_LO];
  assign region_enable = region_select_control_c_reg[`RSC_BIT_EN];
  // The group's own extra wait bit; bit 0 of the first control register here.
  assign extra_wait_bit = select_control_one_reg[0];
  assign bus_error_timer_enable = system_control_register_reg[0];
  assign dram_enable = system_control_register_reg[1];
  // On the fourth region with DRAM on, bit 8 extends size, not strobe timing.
  assign flash_delay = region_select_control_c_reg[`RSC_BIT_FLASH] &
    ~((IS_FOURTH_REGION != 0) & dram_enable);

  // Region size: each code step doubles it, plus one more step when extended.
  assign size_log2 = 6'd`RSC_SIZ_BASE_LOG2 + {3'd0, region_size} +
    {5'd0, (IS_FOURTH_REGION != 0) & dram_enable & region_select_control_c_reg[`RSC_BIT_FLASH]};
  assign up_log2 = 6'd`RSC_UP_BASE_LOG2 + {4'd0, unprotected_block_size};
  assign offset = cpu_addr - region_base;
  assign hit = region_enable & ((offset >> size_log2) == {ADDR_W{1'b0}});
  assign in_protected = (offset >> up_log2) != {ADDR_W{1'b0}};

  // Protection faults that end an access with a bus error.
  assign fault = (cpu_write & region_write_protect & bus_error_timer_enable) |
    (in_protected & ~cpu_supervisor & protected_block_privileged_only & bus_error_timer_enable) |
    (in_protected & cpu_write & protected_block_write_protect);

  // Wait count: twice the code plus the extra wait bit.
  assign wait_load = ({1'b0, wait_count_code[2:0]} << 1) + {{(WAIT_W-1){1'b0}}, extra_wait_bit};

  // APB: zero-wait slave; writes take effect at the access edge.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr = psel & penable & pwrite;

  // Register writes; reserved bits 10 and 9 stay zero whatever software writes.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      region_select_control_c_reg <= `RSC_CTRL_RST;
      select_control_one_reg <= `RSC_ONE_RST;
      system_control_register_reg <= `RSC_SYS_RST;
    end
    else if (apb_wr)
    begin
      if (paddr == `RSC_ADDR_CTRL)
        region_select_control_c_reg <= pwdata[15:0] & `RSC_CTRL_WMASK;
      if (paddr == `RSC_ADDR_ONE)
        select_control_one_reg <= pwdata[7:0];
      if (paddr == `RSC_ADDR_SYS)
        system_control_register_reg <= pwdata[7:0];
    end
  end

  // Read mux; the enable bit is write-only and reads as zero, unmapped reads zero.
  always @*
  begin
    case (paddr)
      `RSC_ADDR_CTRL: prdata = {16'h0000, region_select_control_c_reg[15:1], 1'b0};
      `RSC_ADDR_ONE: prdata = {24'h000000, select_control_one_reg};
      `RSC_ADDR_SYS: prdata = {24'h000000, system_control_register_reg};
      `RSC_ADDR_STAT: prdata = {27'h0000000, err_sticky_reg, state_reg, hit};
      default: prdata = 32'h00000000;
    endcase
  end

  // Access sequencer next state.
  always @*
  begin
    state_next = state_reg;
    wait_next = wait_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (cpu_req & hit & ~fault)
        begin
          wait_next = wait_load;
          if (cpu_write & flash_delay)
            state_next = ST_LEAD;
          else if (wait_count_code == `RSC_WS_EXT)
            state_next = ST_EXT;
          else
            state_next = ST_WAIT;
        end
      end
      ST_LEAD:
        state_next = (wait_count_code == `RSC_WS_EXT) ? ST_EXT : ST_WAIT;
      ST_WAIT:
      begin
        if (wait_reg == {WAIT_W{1'b0}})
          state_next = ST_END;
        else
          wait_next = wait_reg - {{(WAIT_W-1){1'b0}}, 1'b1};
      end
      ST_EXT:
        if (ack_sync)
          state_next = ST_END;
      ST_END:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Sequencer registers and pin drive.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      wait_reg <= {WAIT_W{1'b0}};
      region_select_n <= 1'b1;
      lower_write_strobe_n <= 1'b1;
      upper_write_strobe_n <= 1'b1;
      cpu_done <= 1'b0;
      cpu_bus_error <= 1'b0;
      bus_wide <= 1'b0;
      err_sticky_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      cpu_done <= 1'b0;
      cpu_bus_error <= 1'b0;
      // A fault wins over a clear in the same cycle.
      // A request still held while the error pulse stands is not faulted a second time.
      if (state_reg == ST_IDLE && cpu_req && hit && fault && !cpu_bus_error)
      begin
        cpu_bus_error <= 1'b1;
        err_sticky_reg <= 1'b1;
      end
      else if (apb_wr && paddr == `RSC_ADDR_STAT)
        err_sticky_reg <= 1'b0;
      if (state_next == ST_END)
        cpu_done <= 1'b1;
      // Select is active from start until the end cycle.
      region_select_n <= ~(state_next == ST_LEAD || state_next == ST_WAIT || state_next == ST_EXT);
      // Strobes follow the select, delayed by the lead cycle when flash mode is on.
      if ((state_next == ST_WAIT || state_next == ST_EXT) && cpu_write)
      begin
        lower_write_strobe_n <= 1'b0;
        upper_write_strobe_n <= ~bus_width_select;
      end
      else
      begin
        lower_write_strobe_n <= 1'b1;
        upper_write_strobe_n <= 1'b1;
      end
      bus_wide <= bus_width_select;
    end
  end
endmodule
